// File: design/ssoc_top.v
// sync/status/output-control register bank: registers, output clock and pin control, sync filter, activity and
// polarity detection. assumes sync and clamp pins are asynchronous, select and field inputs come from clk_i logic
//
// Functional notes
// [R1] drive code 00 low, 01 medium, 1x high
// [R2] clock-invert bit inverts the output clock
// [R3] clock select: pixel, 90 degree, double, half
// [R4] global tristate floats all but green sync
// [R5] own bit floats the green sync output
// [R6] field polarity bit swaps odd/even output level
// [R7] PLL reference raw or filtered sync
// [R8] sync processor reference raw or regenerated sync
// [R9] software writes one to control bit zero
// [R10] software keeps reserved registers at default
// [R11] window width in 25 ns steps gates sync
// [R12] horizontal sync inputs report toggle activity
// [R13] vertical sync inputs report toggle activity
// [R14] green sync inputs report toggle activity
// [R15] shared clock/coast pin reports activity
// [R16] clamp input activity on lowest status bit
// [R17] horizontal sync polarity, one means positive
// [R18] vertical sync polarity, one means positive
// [R19] coast polarity has its own status bit
// [R20] coast polarity zero negative, one positive
// [R21] power management reads hsync and sog flags
// [R22] activity flag clears after edgeless timeout
// [R23] polarity: shorter level is the active one
`timescale 1ns/1ns
`include "ssoc_regs.vh"

module ssoc_top #(
	parameter ACT_TIMEOUT_CYC = `SSOC_ACT_TIMEOUT_NS / `SSOC_CLK_NS
) (
	input  wire                      clk_i,
	input  wire                      reset_i,
	input  wire [`SSOC_ADDR_W-1:0]   addr_i,
	input  wire [`SSOC_DATA_W-1:0]   wdata_i,
	input  wire                      wr_i,
	input  wire                      rd_i,
	output reg  [`SSOC_DATA_W-1:0]   rdata_o,
	input  wire                      horiz_sync_input_first_i,
	input  wire                      horiz_sync_input_second_i,
	input  wire                      vert_sync_input_first_i,
	input  wire                      vert_sync_input_second_i,
	input  wire                      green_sync_input_first_i,
	input  wire                      green_sync_input_second_i,
	input  wire                      ext_clock_or_hold_pin_i,
	input  wire                      clamp_pin_i,
	input  wire                      input_sel_i,
	input  wire                      sync_on_green_sel_i,
	input  wire                      field_odd_i,
	output reg                       out_clk_o,
	output reg                       out_clk_oe_n_o,
	output reg                       field_o,
	output reg                       field_oe_n_o,
	output reg                       vertical_sync_output_o,
	output reg                       vertical_sync_output_oe_n_o,
	output reg                       green_sync_output_o,
	output reg                       green_sync_output_oe_n_o,
	output reg  [1:0]                drive_strength_o,
	output reg                       pll_ref_o,
	output reg                       sync_proc_ref_o,
	output reg                       power_sync_present_o
);

	reg  [7:0]                  drive_clk_reg;
	reg  [7:0]                  clk_sync_reg;
	reg  [7:0]                  rsvd_a_reg;
	reg  [7:0]                  rsvd_b_reg;
	reg  [7:0]                  win_width_reg;
	reg  [7:0]                  sync1_reg;
	reg  [7:0]                  sync2_reg;
	reg  [7:0]                  prev_reg;
	reg  [1:0]                  primed_reg;
	wire                        primed;
	reg  [7:0]                  act_reg;
	reg  [7:0]                  seen_reg;
	reg  [5:0]                  pol_reg;
	reg  [`SSOC_ACT_CNT_W-1:0]  tmo_reg;
	reg                         tmo_tick_reg;
	reg  [2:0]                  div_reg;
	reg                         active_prev_reg;
	reg  [`SSOC_LINE_CNT_W-1:0] line_cnt_reg;
	reg  [`SSOC_LINE_CNT_W-1:0] period_reg;
	reg                         locked_reg;
	reg                         gate_reg;
	reg                         regen_reg;
	reg                         extra_reg;
	reg                         extra_line_reg;
	reg  [7:0]                  rdata_next;
	reg                         clk_sel_next;
	reg  [1:0]                  drive_next;
	wire [7:0]                  pin_vec;
	wire [7:0]                  edge_vec;
	wire [5:0]                  pol_in;
	wire [5:0]                  pol_prev;
	wire                        raw_h;
	wire                        raw_s;
	wire                        raw_sync;
	wire                        sel_pol;
	wire                        active;
	wire                        lead;
	wire [15:0]                 win_prod;
	wire [15:0]                 win_div;
	wire [16:0]                 win_cyc;
	wire [16:0]                 lo_lim;
	wire [16:0]                 hi_lim;
	wire                        in_win;
	wire                        overrun;
	wire [7:0]                  pol_stat;

	// pin order matches the activity status bits: h0 h1 v0 v1 g0 g1 coast clamp
	assign pin_vec = {horiz_sync_input_first_i, horiz_sync_input_second_i,
	                  vert_sync_input_first_i, vert_sync_input_second_i,
	                  green_sync_input_first_i, green_sync_input_second_i,
	                  ext_clock_or_hold_pin_i, clamp_pin_i};

	always @(posedge clk_i) begin
		if (reset_i) begin
			sync1_reg <= 8'h00;
			sync2_reg <= 8'h00;
			prev_reg  <= 8'h00;
			primed_reg <= 2'h0;
		end else begin
			sync1_reg <= pin_vec;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
			if (primed_reg != `SSOC_PRIME_DONE)
				primed_reg <= primed_reg + 2'h1;
		end
	end

	// edges count only once the whole pipe holds real pin levels;
	// otherwise the zeros left by reset look like an edge on every idle-high pin
	assign primed   = (primed_reg == `SSOC_PRIME_DONE);
	assign edge_vec = (sync2_reg ^ prev_reg) & {8{primed}};

	// register port; reserved registers simply hold what software leaves in them
	always @(posedge clk_i) begin
		if (reset_i) begin
			drive_clk_reg <= `SSOC_RST_DRIVE_CLK;
			clk_sync_reg  <= `SSOC_RST_CLK_SYNC;
			rsvd_a_reg    <= `SSOC_RST_RSVD_A;  // see [R10]
			rsvd_b_reg    <= `SSOC_RST_RSVD_B;  // see [R10]
			win_width_reg <= `SSOC_RST_WIN_WIDTH;
		end else if (wr_i) begin
			case (addr_i)
				`SSOC_ADDR_DRIVE_CLK: drive_clk_reg <= wdata_i;
				`SSOC_ADDR_CLK_SYNC:  clk_sync_reg  <= wdata_i;  // see [R9]
				`SSOC_ADDR_RSVD_A:    rsvd_a_reg    <= wdata_i;
				`SSOC_ADDR_RSVD_B:    rsvd_b_reg    <= wdata_i;
				`SSOC_ADDR_WIN_WIDTH: win_width_reg <= wdata_i;
				default: ;
			endcase
		end
	end

	// polarity status: h0 h1 v0 v1 coast clamp, then extraneous pulses and filter lock
	assign pol_stat = {pol_reg, extra_reg, locked_reg};  // see [R19]

	always @* begin
		case (addr_i)
			`SSOC_ADDR_DRIVE_CLK: rdata_next = drive_clk_reg;
			`SSOC_ADDR_CLK_SYNC:  rdata_next = clk_sync_reg;
			`SSOC_ADDR_RSVD_A:    rdata_next = rsvd_a_reg;
			`SSOC_ADDR_RSVD_B:    rdata_next = rsvd_b_reg;
			`SSOC_ADDR_WIN_WIDTH: rdata_next = win_width_reg;
			`SSOC_ADDR_ACT_STAT:  rdata_next = act_reg;
			`SSOC_ADDR_POL_STAT:  rdata_next = pol_stat;
			default:              rdata_next = 8'h00;
		endcase
	end

	always @(posedge clk_i) begin
		if (reset_i)
			rdata_o <= 8'h00;
		else if (rd_i)
			rdata_o <= rdata_next;
		else
			rdata_o <= 8'h00;
	end

	// shared activity timeout interval
	always @(posedge clk_i) begin
		if (reset_i) begin
			tmo_reg      <= {`SSOC_ACT_CNT_W{1'b0}};
			tmo_tick_reg <= 1'b0;
		end else if (tmo_reg == ACT_TIMEOUT_CYC[`SSOC_ACT_CNT_W-1:0] - 1'b1) begin
			tmo_reg      <= {`SSOC_ACT_CNT_W{1'b0}};
			tmo_tick_reg <= 1'b1;
		end else begin
			tmo_reg      <= tmo_reg + 1'b1;
			tmo_tick_reg <= 1'b0;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : gen_act
			// an edge sets the flag at once; an interval with no edge clears it
			always @(posedge clk_i) begin
				if (reset_i) begin
					act_reg[g]  <= 1'b0;
					seen_reg[g] <= 1'b0;
				end else if (tmo_tick_reg) begin
					act_reg[g]  <= seen_reg[g] | edge_vec[g];  // see [R22] [R12] [R13] [R14] [R15] [R16]
					seen_reg[g] <= 1'b0;
				end else if (edge_vec[g]) begin
					act_reg[g]  <= 1'b1;
					seen_reg[g] <= 1'b1;
				end
			end
		end
	endgenerate

	assign pol_in   = {sync2_reg[7:4], sync2_reg[1:0]};
	assign pol_prev = {prev_reg[7:4], prev_reg[1:0]};

	generate
		for (g = 0; g < 6; g = g + 1) begin : gen_pol
			reg [`SSOC_POL_CNT_W-1:0] hi_cnt_reg;
			reg [`SSOC_POL_CNT_W-1:0] lo_cnt_reg;
			// at each rising edge the level that lasted less over the last period is the active one
			always @(posedge clk_i) begin
				if (reset_i) begin
					hi_cnt_reg <= {`SSOC_POL_CNT_W{1'b0}};
					lo_cnt_reg <= {`SSOC_POL_CNT_W{1'b0}};
					pol_reg[g] <= 1'b0;
				end else if (primed & pol_in[g] & ~pol_prev[g]) begin
					pol_reg[g] <= (hi_cnt_reg < lo_cnt_reg);  // see [R23] [R17] [R18] [R20]
					hi_cnt_reg <= {{(`SSOC_POL_CNT_W-1){1'b0}}, 1'b1};
					lo_cnt_reg <= {`SSOC_POL_CNT_W{1'b0}};
				end else if (pol_in[g]) begin
					if (~&hi_cnt_reg)
						hi_cnt_reg <= hi_cnt_reg + 1'b1;
				end else begin
					if (~&lo_cnt_reg)
						lo_cnt_reg <= lo_cnt_reg + 1'b1;
				end
			end
		end
	endgenerate

	// selected raw sync and its leading edge, normalised by detected hsync polarity; sync on green is taken as active low
	assign raw_h    = input_sel_i ? sync2_reg[6] : sync2_reg[7];
	assign raw_s    = input_sel_i ? sync2_reg[2] : sync2_reg[3];
	assign raw_sync = sync_on_green_sel_i ? raw_s : raw_h;
	assign sel_pol  = sync_on_green_sel_i ? 1'b0 : (input_sel_i ? pol_reg[4] : pol_reg[5]);
	assign active   = sel_pol ? raw_sync : ~raw_sync;
	assign lead     = active & ~active_prev_reg & primed;

	// tolerance window in clock cycles, never below one
	assign win_prod = {8'h00, win_width_reg} * `SSOC_WIN_STEP_W16;
	assign win_div  = win_prod / `SSOC_CLK_NS_W16;
	assign win_cyc  = (win_div == 16'h0000) ? 17'h00001 : {1'b0, win_div};
	assign lo_lim   = ({1'b0, period_reg} > win_cyc) ? ({1'b0, period_reg} - win_cyc) : 17'h00000;
	assign hi_lim   = {1'b0, period_reg} + win_cyc;
	assign in_win   = ({1'b0, line_cnt_reg} >= lo_lim) && ({1'b0, line_cnt_reg} <= hi_lim);  // see [R11]
	assign overrun  = {1'b0, line_cnt_reg} > hi_lim;

	always @(posedge clk_i) begin
		if (reset_i) begin
			active_prev_reg <= 1'b0;
			line_cnt_reg    <= {`SSOC_LINE_CNT_W{1'b0}};
			period_reg      <= {`SSOC_LINE_CNT_W{1'b0}};
			locked_reg      <= 1'b0;
			gate_reg        <= 1'b0;
			regen_reg       <= 1'b0;
			extra_reg       <= 1'b0;
			extra_line_reg  <= 1'b0;
		end else begin
			active_prev_reg <= active;
			regen_reg       <= 1'b0;
			if (~&line_cnt_reg)
				line_cnt_reg <= line_cnt_reg + 1'b1;
			if (~active)
				gate_reg <= 1'b0;
			if (lead && (in_win || !locked_reg)) begin
				// accepted edge: new line starts and the pulse may pass
				period_reg     <= line_cnt_reg;
				line_cnt_reg   <= {{(`SSOC_LINE_CNT_W-1){1'b0}}, 1'b1};
				locked_reg     <= in_win && (period_reg != {`SSOC_LINE_CNT_W{1'b0}});
				gate_reg       <= 1'b1;  // see [R11]
				regen_reg      <= 1'b1;
				extra_reg      <= extra_line_reg;
				extra_line_reg <= 1'b0;
			end else if (lead) begin
				extra_line_reg <= 1'b1;
				extra_reg      <= 1'b1;
			end else if (overrun) begin
				locked_reg <= 1'b0;
			end
		end
	end

	// output clock source: pixel rate is a quarter of clk_i
	always @* begin
		case (clk_sync_reg[`SSOC_F_OCLK_HI:`SSOC_F_OCLK_LO])  // see [R3]
			`SSOC_OCLK_PIX:    clk_sel_next = div_reg[1];
			`SSOC_OCLK_PIX90:  clk_sel_next = div_reg[1] ^ div_reg[0];
			`SSOC_OCLK_DOUBLE: clk_sel_next = div_reg[0];
			`SSOC_OCLK_HALF:   clk_sel_next = div_reg[2];
			default:           clk_sel_next = div_reg[1];
		endcase
	end

	always @* begin
		if (drive_clk_reg[`SSOC_F_DRV_HI])  // see [R1]
			drive_next = `SSOC_DRV_HIGH;
		else if (drive_clk_reg[`SSOC_F_DRV_LO])
			drive_next = `SSOC_DRV_MED;
		else
			drive_next = `SSOC_DRV_LOW;
	end

	always @(posedge clk_i) begin
		if (reset_i) begin
			div_reg                     <= 3'h0;
			out_clk_o                   <= 1'b0;
			out_clk_oe_n_o              <= 1'b0;
			field_o                     <= 1'b0;
			field_oe_n_o                <= 1'b0;
			vertical_sync_output_o      <= 1'b0;
			vertical_sync_output_oe_n_o <= 1'b0;
			green_sync_output_o         <= 1'b0;
			green_sync_output_oe_n_o    <= 1'b0;
			drive_strength_o            <= `SSOC_DRV_HIGH;
			pll_ref_o                   <= 1'b0;
			sync_proc_ref_o             <= 1'b0;
			power_sync_present_o        <= 1'b0;
		end else begin
			div_reg                     <= div_reg + 3'h1;
			out_clk_o                   <= clk_sel_next ^ drive_clk_reg[`SSOC_F_CLK_INV];  // see [R2]
			out_clk_oe_n_o              <= clk_sync_reg[`SSOC_F_TRI];  // see [R4]
			field_o                     <= field_odd_i ^ clk_sync_reg[`SSOC_F_FPOL];  // see [R6]
			field_oe_n_o                <= clk_sync_reg[`SSOC_F_TRI];  // see [R4]
			vertical_sync_output_o      <= input_sel_i ? sync2_reg[4] : sync2_reg[5];
			vertical_sync_output_oe_n_o <= clk_sync_reg[`SSOC_F_TRI];  // see [R4]
			green_sync_output_o         <= raw_s;
			green_sync_output_oe_n_o    <= clk_sync_reg[`SSOC_F_SOG_TRI];  // see [R5]
			drive_strength_o            <= drive_next;
			pll_ref_o                   <= clk_sync_reg[`SSOC_F_PLL_SRC] ? (active & gate_reg) : raw_sync;  // see [R7]
			sync_proc_ref_o             <= clk_sync_reg[`SSOC_F_SP_SRC] ? regen_reg : raw_sync;  // see [R8]
			power_sync_present_o        <= act_reg[7] | act_reg[6] | act_reg[3] | act_reg[2];  // see [R21]
		end
	end

endmodule

// File: design/ssoc_regs.vh
// register offsets, field positions, reset values and timing figures of the sync/status/output-control bank
// assumes it is included by bare name from the design file and defines nothing but macros
`ifndef SSOC_REGS_VH
`define SSOC_REGS_VH

`define SSOC_ADDR_W           8
`define SSOC_DATA_W           8

`define SSOC_ADDR_DRIVE_CLK   8'h1f
`define SSOC_ADDR_CLK_SYNC    8'h20
`define SSOC_ADDR_RSVD_A      8'h21
`define SSOC_ADDR_RSVD_B      8'h22
`define SSOC_ADDR_WIN_WIDTH   8'h23
`define SSOC_ADDR_ACT_STAT    8'h24
`define SSOC_ADDR_POL_STAT    8'h25

`define SSOC_RST_DRIVE_CLK    8'h94
`define SSOC_RST_CLK_SYNC     8'h00
`define SSOC_RST_RSVD_A       8'h00
`define SSOC_RST_RSVD_B       8'h00
`define SSOC_RST_WIN_WIDTH    8'h0a

`define SSOC_F_DRV_HI         2
`define SSOC_F_DRV_LO         1
`define SSOC_F_CLK_INV        0
`define SSOC_F_OCLK_HI        7
`define SSOC_F_OCLK_LO        6
`define SSOC_F_TRI            5
`define SSOC_F_SOG_TRI        4
`define SSOC_F_FPOL           3
`define SSOC_F_PLL_SRC        2
`define SSOC_F_SP_SRC         1

`define SSOC_DRV_LOW          2'h0
`define SSOC_DRV_MED          2'h1
`define SSOC_DRV_HIGH         2'h2

`define SSOC_OCLK_PIX         2'h0
`define SSOC_OCLK_PIX90       2'h1
`define SSOC_OCLK_DOUBLE      2'h2
`define SSOC_OCLK_HALF        2'h3

`define SSOC_CLK_NS           100
`define SSOC_WIN_STEP_NS      25
`define SSOC_WIN_STEP_W16     16'h0019
`define SSOC_CLK_NS_W16       16'h0064
`define SSOC_PRIME_DONE       2'h3
`define SSOC_ACT_TIMEOUT_NS   100000000
`define SSOC_ACT_CNT_W        20
`define SSOC_POL_CNT_W        16
`define SSOC_LINE_CNT_W       16

`endif

// File: tb/ssoc_top_monitor.sv
// assertions on the ports of the sync/status/output-control bank
// assumes it is bound into ssoc_top and shares its clock and reset
`timescale 1ns/1ns
module ssoc_mon #(
	parameter ACT_TIMEOUT_CYC = 64
) (
	input wire       clk_i,
	input wire       reset_i,
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	input wire       wr_i,
	input wire       rd_i,
	input wire [7:0] rdata_o,
	input wire       horiz_sync_input_first_i,
	input wire       horiz_sync_input_second_i,
	input wire       green_sync_input_first_i,
	input wire       green_sync_input_second_i,
	input wire       field_odd_i,
	input wire       field_o,
	input wire       out_clk_oe_n_o,
	input wire       field_oe_n_o,
	input wire       vertical_sync_output_oe_n_o,
	input wire       green_sync_output_oe_n_o,
	input wire [1:0] drive_strength_o,
	input wire       power_sync_present_o
);
	wire [3:0]  sv = {horiz_sync_input_first_i, horiz_sync_input_second_i,
		green_sync_input_first_i, green_sync_input_second_i};
	reg  [3:0]  prv_reg;
	reg  [15:0] idle_reg;
	// cycles since any line-sync pin last moved, saturating
	always @(posedge clk_i) begin
		prv_reg <= sv;
		if (reset_i || prv_reg != sv)
			idle_reg <= 16'h0000;
		else if (idle_reg != 16'hffff)
			idle_reg <= idle_reg + 16'h0001;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not zero outside a read answer");
	unmapped_zero_a: assert property (rd_i && (addr_i < 8'h1f || addr_i > 8'h25) |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	drive_map_a: assert property (wr_i && addr_i == 8'h1f |-> ##2
		drive_strength_o == ((|($past(wdata_i, 2) & 8'h04)) ? 2'h2 : {1'b0, |($past(wdata_i, 2) & 8'h02)}))
		else $error("drive strength does not follow its field");
	drive_legal_a: assert property (drive_strength_o != 2'h3)
		else $error("drive strength code out of range");
	tri_main_a: assert property (wr_i && addr_i == 8'h20 |-> ##2
		out_clk_oe_n_o == |($past(wdata_i, 2) & 8'h20))
		else $error("output clock enable does not follow tristate bit");
	tri_same_a: assert property (field_oe_n_o == out_clk_oe_n_o && vertical_sync_output_oe_n_o == out_clk_oe_n_o)
		else $error("outputs not floated together");
	sog_tri_a: assert property (wr_i && addr_i == 8'h20 |-> ##2
		green_sync_output_oe_n_o == |($past(wdata_i, 2) & 8'h10))
		else $error("green sync enable does not follow its bit");
	field_pol_a: assert property (wr_i && addr_i == 8'h20 |-> ##2
		field_o == ($past(field_odd_i) ^ |($past(wdata_i, 2) & 8'h08)))
		else $error("field output polarity wrong");
	act_set_a: assert property ($changed(sv) |-> ##[1:6] power_sync_present_o)
		else $error("sync activity not reported");
	act_clear_a: assert property (idle_reg > 2 * ACT_TIMEOUT_CYC + 8 |-> !power_sync_present_o)
		else $error("sync activity kept without edges");
endmodule

bind ssoc_top ssoc_mon #(.ACT_TIMEOUT_CYC(ACT_TIMEOUT_CYC)) u_mon (
	.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .horiz_sync_input_first_i(horiz_sync_input_first_i),
	.horiz_sync_input_second_i(horiz_sync_input_second_i), .green_sync_input_first_i(green_sync_input_first_i),
	.green_sync_input_second_i(green_sync_input_second_i), .field_odd_i(field_odd_i), .field_o(field_o),
	.out_clk_oe_n_o(out_clk_oe_n_o), .field_oe_n_o(field_oe_n_o),
	.vertical_sync_output_oe_n_o(vertical_sync_output_oe_n_o),
	.green_sync_output_oe_n_o(green_sync_output_oe_n_o), .drive_strength_o(drive_strength_o),
	.power_sync_present_o(power_sync_present_o));

// File: tb/ssoc_sync_src.sv
// video source model: sync, coast and clamp pins of the capture front end
// assumes clk_i is the bench clock; pins move just after its rising edge
`timescale 1ns/1ns
module ssoc_sync_src #(
	parameter PERIOD = 20,
	parameter HIGH   = 5
) (
	input  wire       clk_i,
	input  wire [7:0] en_i,
	input  wire [7:0] pol_i,
	output reg  [7:0] pin_o = 8'hff
);
	integer cnt = 0;
	// enabled pins pulse to pol_i for HIGH cycles of each PERIOD, others rest at ~pol_i
	always @(posedge clk_i) begin
		cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
		pin_o <= ~(pol_i ^ (en_i & {8{cnt < HIGH}}));
	end
endmodule

// File: tb/sync_status_output_control_bench.sv
// bench for the sync/status/output-control bank: register port, output pins, sync status
// assumes ssoc_top, ssoc_mon and ssoc_sync_src are compiled before it
`timescale 1ns/1ns
module sync_status_output_control_bench;
	localparam T = 64;
	reg         clk_i   = 1'b0;
	reg         reset_i = 1'b1;
	reg  [7:0]  addr_i  = 8'h00;
	reg  [7:0]  wdata_i = 8'h00;
	reg         wr_i    = 1'b0;
	reg         rd_i    = 1'b0;
	reg         isel    = 1'b0;
	reg         gsel    = 1'b0;
	reg         fodd    = 1'b0;
	reg  [7:0]  en      = 8'h00;
	reg  [7:0]  pol     = 8'h00;
	wire [7:0]  pin;
	wire [7:0]  rdata_o;
	wire        ock, ock_oe, fld, fld_oe, vs_oe, gs_oe, psp;
	wire [1:0]  drv;
	wire        vso, gso, pref, sref, rs;
	reg  [7:0]  pd1, pd2, pd3;
	logic [7:0] mdl [0:255];
	logic [7:0] got;
	logic       prev;
	integer     n_fail = 0;
	integer     check_count = 0;
	integer     i, k, nchg;
	always #50 clk_i = ~clk_i;
	// pins as the design sees them three stages on: two synchroniser flops and the output flop
	always @(posedge clk_i) begin
		pd1 <= pin;
		pd2 <= pd1;
		pd3 <= pd2;
	end
	assign rs = gsel ? (isel ? pd3[2] : pd3[3]) : (isel ? pd3[6] : pd3[7]);
	ssoc_sync_src src (.clk_i(clk_i), .en_i(en), .pol_i(pol), .pin_o(pin));
	ssoc_top #(.ACT_TIMEOUT_CYC(T)) dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .horiz_sync_input_first_i(pin[7]),
		.horiz_sync_input_second_i(pin[6]), .vert_sync_input_first_i(pin[5]), .vert_sync_input_second_i(pin[4]),
		.green_sync_input_first_i(pin[3]), .green_sync_input_second_i(pin[2]), .ext_clock_or_hold_pin_i(pin[1]),
		.clamp_pin_i(pin[0]), .input_sel_i(isel), .sync_on_green_sel_i(gsel), .field_odd_i(fodd),
		.out_clk_o(ock), .out_clk_oe_n_o(ock_oe), .field_o(fld), .field_oe_n_o(fld_oe),
		.vertical_sync_output_o(vso), .vertical_sync_output_oe_n_o(vs_oe), .green_sync_output_o(gso),
		.green_sync_output_oe_n_o(gs_oe), .drive_strength_o(drv), .pll_ref_o(pref), .sync_proc_ref_o(sref),
		.power_sync_present_o(psp));
	task chk(input logic [7:0] g, input logic [7:0] e);
		check_count = check_count + 1;
		if (g !== e) begin
			n_fail = n_fail + 1;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= w;
		rd_i <= !w;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b0;
		@(negedge clk_i);
		got = rdata_o;
		if (w && a >= 8'h1f && a <= 8'h23)
			mdl[a] = d;
	endtask
	task rdchk(input logic [7:0] a);
		bus(1'b0, a, 8'h00);
		chk(got, mdl[a]);
	endtask
	task summarize;
		$display("fails %0d checks %0d", n_fail, check_count);
		if (n_fail == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#(100 * 20000);
		n_fail = n_fail + 1;
		summarize;
	end
	initial begin
		for (i = 0; i < 256; i = i + 1)
			mdl[i] = 8'h00;
		mdl[8'h1f] = 8'h94;
		mdl[8'h23] = 8'h0a;
		i = $urandom(33688);
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		for (i = 8'h1c; i < 8'h28; i = i + 1)
			rdchk(i[7:0]);
		rdchk(8'hff);
		// random writes with read-back, status and unmapped writes ignored
		for (k = 0; k < 16; k = k + 1) begin
			i = 8'h1c + $urandom % 12;
			got = 8'($urandom);
			if (i == 8'h20) got[0] = 1'b1;
			if (i == 8'h21 || i == 8'h22) got = 8'h00;
			bus(1'b1, i[7:0], got);
			rdchk(i[7:0]);
		end
		// every drive code and clock source, counting output clock changes
		for (k = 0; k < 4; k = k + 1) begin
			i = $urandom;
			bus(1'b1, 8'h1f, {5'h12, k[1:0], i[0]});
			bus(1'b1, 8'h20, {k[1:0], 6'h01});
			@(negedge clk_i);
			chk({6'h00, drv}, k[1] ? 8'h02 : k[7:0]);
			prev = ock;
			nchg = 0;
			repeat (32) begin
				@(negedge clk_i);
				nchg = nchg + (ock !== prev);
				prev = ock;
			end
			chk(nchg[7:0], k == 2 ? 8'h20 : k == 3 ? 8'h08 : 8'h10);
		end
		for (k = 0; k < 8; k = k + 1) begin
			fodd <= 1'($urandom);
			bus(1'b1, 8'h20, {2'h0, k[2:0], 3'h1});
			@(negedge clk_i);
			chk({3'h0, ock_oe, fld_oe, vs_oe, gs_oe, fld}, {3'h0, k[2], k[2], k[2], k[1], fodd ^ k[0]});
		end
		isel <= 1'($urandom);
		gsel <= 1'($urandom);
		for (k = 0; k < 4; k = k + 1) begin
			en <= 8'h00;
			pol <= 8'($urandom);
			repeat (2 * T + 20) @(posedge clk_i);
			rdchk(8'h24);
			en <= 8'($urandom);
			repeat (80) @(posedge clk_i);
			mdl[8'h24] = en;
			rdchk(8'h24);
			bus(1'b0, 8'h25, 8'h00);
			chk(got & {en[7:4], en[1:0], 2'h0}, {pol[7:4], pol[1:0], 2'h0} & {en[7:4], en[1:0], 2'h0});
			chk({7'h00, psp}, {7'h00, |(en & 8'hcc)});
			// control register holds raw sources here: both references follow the selected raw sync
			repeat (40) begin
				@(negedge clk_i);
				chk({4'h0, vso, gso, pref, sref}, {4'h0, isel ? pd3[4] : pd3[5], isel ? pd3[2] : pd3[3], rs, rs});
			end
			mdl[8'h24] = 8'h00;
		end
		summarize;
	end
endmodule
